/* File: icd_pkg.sv */
// constants and field layout for the input channel disable logic
package icd_pkg;

  // ****************************************************
  // bus geometry
  // ****************************************************
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;

  // ****************************************************
  // register offsets
  // ****************************************************
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_RISE = 4'h1;
  localparam logic [3:0] ADDR_FALL = 4'h2;
  localparam logic [3:0] ADDR_STAT = 4'h3;

  // ****************************************************
  // control fields
  // ****************************************************
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_POL_BIT = 1;
  localparam int unsigned CTRL_FUNC_LSB = 2;
  localparam int unsigned CTRL_MODE_LSB = 4;
  localparam int unsigned CTRL_START_LSB = 6;
  localparam int unsigned CTRL_END_LSB = 8;
  localparam logic [15:0] CTRL_MASK = 16'h03FF;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] RISE_RESET = 16'h0000;
  localparam logic [15:0] FALL_RESET = 16'h0000;

  // ****************************************************
  // status fields
  // ****************************************************
  localparam int unsigned STAT_DIS_BIT = 0;
  localparam int unsigned STAT_LEVEL_BIT = 1;

  // ****************************************************
  // field codes
  // ****************************************************
  localparam logic [1:0] MODE_RISE = 2'h0;
  localparam logic [1:0] MODE_FALL = 2'h1;
  localparam logic [1:0] MODE_BOTH = 2'h2;
  localparam logic [1:0] REACT_NONE = 2'h0;
  localparam logic [1:0] REACT_RISE = 2'h1;
  localparam logic [1:0] REACT_FALL = 2'h2;
  localparam logic [1:0] REACT_STATE = 2'h3;
  localparam logic [1:0] FUNC_SCENE = 2'h0;
  localparam logic [1:0] FUNC_SCENE_MEM = 2'h1;
  localparam logic [1:0] FUNC_TEMP = 2'h2;

endpackage : icd_pkg

/* File: icd_disable_logic.sv */
// input channel disable logic: gating, start and end reactions, register port
`timescale 1ns/10ps
module icd_disable_logic
  import icd_pkg::*;
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic RSTN,
  // register port
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [DATA_W-1:0] RDATA,
  // channel side
  input wire logic DISABLE_OBJ,
  input wire logic INPUT_PIN,
  // telegram transmit path
  output logic TX_VALID,
  output logic [DATA_W-1:0] TX_DATA
);

  // ****************************************************
  // decode helpers
  // ****************************************************
  function automatic logic rise_ok(input logic [1:0] func, input logic [1:0] mode);
    if (func == FUNC_SCENE_MEM) begin
      return mode == MODE_RISE;
    end
    return (mode == MODE_RISE) || (mode == MODE_BOTH);
  endfunction : rise_ok

  function automatic logic fall_ok(input logic [1:0] func, input logic [1:0] mode);
    if (func == FUNC_SCENE_MEM) begin
      return mode == MODE_FALL;
    end
    return (mode == MODE_FALL) || (mode == MODE_BOTH);
  endfunction : fall_ok

  // returns {send, value} for one reaction code
  function automatic logic [DATA_W:0] react(input logic [1:0] code, input logic [1:0] func,
                                           input logic [1:0] mode, input logic level,
                                           input logic [DATA_W-1:0] rv,
                                           input logic [DATA_W-1:0] fv);
    logic [DATA_W:0] res;
    res = {1'b0, rv};
    unique case (code)
      REACT_NONE: res = {1'b0, rv};
      REACT_RISE: res = {rise_ok(func, mode), rv};
      REACT_FALL: res = {fall_ok(func, mode), fv};
      // both-edge mode only, no memory variant
      REACT_STATE: begin
        res = {(mode == MODE_BOTH) && (func != FUNC_SCENE_MEM), level ? rv : fv};
      end
    endcase
    return res;
  endfunction : react

  // ****************************************************
  // configuration registers
  // ****************************************************
  logic [DATA_W-1:0] ctrl_r;
  logic [DATA_W-1:0] rise_val_r;
  logic [DATA_W-1:0] fall_val_r;

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl_r <= CTRL_RESET;
      rise_val_r <= RISE_RESET;
      fall_val_r <= FALL_RESET;
    end else if (WR) begin
      if (ADDR == ADDR_CTRL) begin
        ctrl_r <= WDATA & CTRL_MASK;
      end
      if (ADDR == ADDR_RISE) begin
        rise_val_r <= WDATA;
      end
      if (ADDR == ADDR_FALL) begin
        fall_val_r <= WDATA;
      end
    end
  end

  logic en;
  logic pol;
  logic [1:0] func;
  logic [1:0] mode;
  logic [1:0] start_code;
  logic [1:0] end_code;
  assign en = ctrl_r[CTRL_EN_BIT];
  assign pol = ctrl_r[CTRL_POL_BIT];
  assign func = ctrl_r[CTRL_FUNC_LSB +: 2];
  assign mode = ctrl_r[CTRL_MODE_LSB +: 2];
  assign start_code = ctrl_r[CTRL_START_LSB +: 2];
  assign end_code = ctrl_r[CTRL_END_LSB +: 2];

  // ****************************************************
  // input pin conditioning
  // ****************************************************
  // a change is taken only once stages two and three agree
  logic [2:0] sync_r;
  logic level_r;
  logic level_chg;
  logic rise_ev;
  logic fall_ev;

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      sync_r <= 3'h0;
    end else begin
      sync_r <= {sync_r[1:0], INPUT_PIN};
    end
  end

  assign level_chg = (sync_r[1] == sync_r[2]) && (sync_r[2] != level_r);
  assign rise_ev = level_chg && sync_r[2];
  assign fall_ev = level_chg && !sync_r[2];

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      level_r <= 1'b0;
    end else if (level_chg) begin
      level_r <= sync_r[2];
    end
  end

  // ****************************************************
  // effective disable state
  // ****************************************************
  logic dis_nxt;
  logic dis_r;
  logic start_ev;
  logic end_ev;
  logic blocked;

  assign dis_nxt = en && (DISABLE_OBJ ^ pol);

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      dis_r <= 1'b0;
    end else begin
      dis_r <= dis_nxt;
    end
  end

  assign start_ev = dis_nxt && !dis_r;
  assign end_ev = !dis_nxt && dis_r;
  // edges are dropped across the whole disabled span, including its edges
  assign blocked = dis_nxt || dis_r;

  // ****************************************************
  // telegram selection
  // ****************************************************
  logic [DATA_W:0] start_sel;
  logic [DATA_W:0] end_sel;
  logic tx_nxt;
  logic [DATA_W-1:0] tx_data_nxt;

  assign start_sel = react(start_code, func, mode, level_r, rise_val_r, fall_val_r);
  assign end_sel = react(end_code, func, mode, level_r, rise_val_r, fall_val_r);

  always_comb begin
    tx_nxt = 1'b0;
    tx_data_nxt = TX_DATA;
    if (start_ev) begin
      tx_nxt = start_sel[DATA_W];
      tx_data_nxt = start_sel[DATA_W-1:0];
    end else if (end_ev) begin
      tx_nxt = end_sel[DATA_W];
      tx_data_nxt = end_sel[DATA_W-1:0];
    end else if (!blocked && rise_ev && rise_ok(func, mode)) begin
      tx_nxt = 1'b1;
      tx_data_nxt = rise_val_r;
    end else if (!blocked && fall_ev && fall_ok(func, mode)) begin
      tx_nxt = 1'b1;
      tx_data_nxt = fall_val_r;
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      TX_VALID <= 1'b0;
      TX_DATA <= RISE_RESET;
    end else begin
      TX_VALID <= tx_nxt;
      if (tx_nxt) begin
        TX_DATA <= tx_data_nxt;
      end
    end
  end

  // ****************************************************
  // register read port
  // ****************************************************
  logic [DATA_W-1:0] rd_nxt;

  always_comb begin
    rd_nxt = '0;
    if (RD) begin
      unique case (ADDR)
        ADDR_CTRL: rd_nxt = ctrl_r;
        ADDR_RISE: rd_nxt = rise_val_r;
        ADDR_FALL: rd_nxt = fall_val_r;
        ADDR_STAT: begin
          rd_nxt[STAT_DIS_BIT] = dis_r;
          rd_nxt[STAT_LEVEL_BIT] = level_r;
        end
        default: rd_nxt = '0;
      endcase
    end
  end

  // data stand only in the cycle after the strobe
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      RDATA <= '0;
    end else begin
      RDATA <= rd_nxt;
    end
  end

  // ****************************************************
  // checks
  // ****************************************************
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);

  feature_off_a: assert property (!en |=> !dis_r)
    else $error("disable state set while feature off");

  polarity_map_a: assert property (en && (DISABLE_OBJ != pol) |=> dis_r)
    else $error("polarity mapping wrong");

  polarity_clear_a: assert property (en && (DISABLE_OBJ == pol) |=> !dis_r)
    else $error("polarity mapping wrong for the enabling level");

  start_rise_a: assert property (start_ev && start_code == REACT_RISE
    && rise_ok(func, mode) |=> TX_VALID && TX_DATA == $past(rise_val_r))
    else $error("start reaction did not send rising value");

  start_fall_a: assert property (start_ev && start_code == REACT_FALL
    && fall_ok(func, mode) |=> TX_VALID && TX_DATA == $past(fall_val_r))
    else $error("start reaction did not send falling value");

  end_fall_a: assert property (end_ev && end_code == REACT_FALL
    && fall_ok(func, mode) |=> TX_VALID && TX_DATA == $past(fall_val_r))
    else $error("end reaction did not send falling value");

  end_rise_a: assert property (end_ev && end_code == REACT_RISE
    && rise_ok(func, mode) |=> TX_VALID && TX_DATA == $past(rise_val_r))
    else $error("end reaction did not send rising value");

  none_quiet_a: assert property ((start_ev && start_code == REACT_NONE)
    || (end_ev && end_code == REACT_NONE) |=> !TX_VALID)
    else $error("telegram sent for no-action reaction");

  rise_gate_a: assert property (((start_ev && start_code == REACT_RISE)
    || (end_ev && end_code == REACT_RISE)) && !rise_ok(func, mode) |=> !TX_VALID)
    else $error("rising reaction sent outside its modes");

  fall_gate_a: assert property (((start_ev && start_code == REACT_FALL)
    || (end_ev && end_code == REACT_FALL)) && !fall_ok(func, mode) |=> !TX_VALID)
    else $error("falling reaction sent outside its modes");

  state_value_a: assert property (start_ev && start_code == REACT_STATE
    && mode == MODE_BOTH && func != FUNC_SCENE_MEM |=> TX_VALID
    && TX_DATA == ($past(level_r) ? $past(rise_val_r) : $past(fall_val_r)))
    else $error("current-state reaction sent wrong value");

  state_gate_a: assert property ((start_ev && start_code == REACT_STATE
    && mode != MODE_BOTH) |=> !TX_VALID)
    else $error("current-state reaction outside both-edge mode");

  memory_gate_a: assert property (func == FUNC_SCENE_MEM && start_ev
    && start_code == REACT_RISE && mode != MODE_RISE |=> !TX_VALID)
    else $error("memory variant sent rising reaction in wrong mode");

  temp_limits_a: assert property (func == FUNC_TEMP && end_ev
    && end_code == REACT_FALL && mode == MODE_RISE |=> !TX_VALID)
    else $error("temperature sender ignored edge-mode limits");

  edge_send_a: assert property (!blocked && rise_ev && rise_ok(func, mode)
    |=> TX_VALID && TX_DATA == $past(rise_val_r))
    else $error("rising input edge not sent");

  disabled_quiet_a: assert property (dis_r && dis_nxt |=> !TX_VALID)
    else $error("telegram sent while disabled");

  start_seen_c: cover property (start_ev && start_code != REACT_NONE ##1 TX_VALID);
  end_seen_c: cover property (end_ev ##1 TX_VALID);
  state_seen_c: cover property (start_ev && start_code == REACT_STATE ##1 TX_VALID);
  edge_send_c: cover property (!blocked && rise_ev ##1 TX_VALID);
  edge_masked_c: cover property (dis_r && dis_nxt && level_chg);

endmodule : icd_disable_logic

/* File: icd_bus_partner.sv */
// model of the bus side: disabling object source and telegram sink
`timescale 1ns/10ps
module icd_bus_partner (
  // clock and reset
  input logic clock,
  input logic rstn,
  // disabling object
  input logic obj_req,
  output logic disable_obj,
  // telegram path
  input logic tx_valid,
  input logic [15:0] tx_data,
  output logic [15:0] tx_count,
  output logic [15:0] tx_last
);
  // ****************************************
  // object and telegram capture
  // ****************************************
  // object arrives one clock after the request, like a received telegram
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      disable_obj <= 1'b0;
    end else begin
      disable_obj <= obj_req;
    end
  end

  // data taken in the pulse cycle only, since TX_DATA may hold stale values
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tx_count <= 16'h0000;
      tx_last <= 16'h0000;
    end else if (tx_valid) begin
      tx_count <= tx_count + 16'h0001;
      tx_last <= tx_data;
    end
  end
endmodule : icd_bus_partner

/* File: test_input_channel_disable_logic.sv */
// self-checking testbench for the input channel disable logic
`timescale 1ns/10ps
module test_input_channel_disable_logic;
  import icd_pkg::*;
  // ****************************************
  // signals and helpers
  // ****************************************
  localparam logic [15:0] RISE_V = 16'h00A5;
  localparam logic [15:0] FALL_V = 16'h005A;
  logic CLOCK = 1'b0;
  logic RSTN = 1'b0;
  logic [3:0] ADDR = 4'h0;
  logic [15:0] WDATA = 16'h0000;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [15:0] RDATA;
  logic DISABLE_OBJ;
  logic INPUT_PIN = 1'b0;
  logic TX_VALID;
  logic [15:0] TX_DATA;
  logic obj_req = 1'b0;
  logic [15:0] tx_count;
  logic [15:0] tx_last;
  logic [15:0] c0;
  int err_count = 0;
  int checks = 0;
  int cycles = 0;

  always #12.5 CLOCK = ~CLOCK;

  icd_disable_logic icd_disable_logic_inst (.CLOCK(CLOCK), .RSTN(RSTN), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .DISABLE_OBJ(DISABLE_OBJ),
    .INPUT_PIN(INPUT_PIN), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA));
  icd_bus_partner icd_bus_partner_inst (.clock(CLOCK), .rstn(RSTN), .obj_req(obj_req),
    .disable_obj(DISABLE_OBJ), .tx_valid(TX_VALID), .tx_data(TX_DATA),
    .tx_count(tx_count), .tx_last(tx_last));

  task automatic print_verdict();
    $display("checks=%0d errors=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  // whole run is a few thousand cycles
  always @(posedge CLOCK) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge CLOCK);
  endtask : tick

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge CLOCK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLOCK);
    WR <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp, input string what);
    @(posedge CLOCK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLOCK);
    RD <= 1'b0;
    #1;
    check(what, exp, RDATA);
  endtask : rd_chk

  // pin passes a 3-flop synchroniser, so allow settling time
  task automatic pin(input logic v);
    @(posedge CLOCK);
    INPUT_PIN <= v;
    tick(8);
  endtask : pin

  task automatic obj(input logic v);
    @(posedge CLOCK);
    obj_req <= v;
  endtask : obj

  // exp[16] says whether one telegram is due, exp[15:0] its value
  task automatic tx_chk(input logic [16:0] exp, input string what);
    tick(6);
    check(what, {15'h0000, exp[16]}, tx_count - c0);
    if (exp[16]) begin
      check(what, exp[15:0], tx_last);
    end
    c0 = tx_count;
  endtask : tx_chk

  function automatic logic [16:0] exp_tx(input logic [1:0] f, m, r, input logic lvl);
    logic rok;
    logic fok;
    rok = (f == FUNC_SCENE_MEM) ? (m == MODE_RISE) : (m == MODE_RISE || m == MODE_BOTH);
    fok = (f == FUNC_SCENE_MEM) ? (m == MODE_FALL) : (m == MODE_FALL || m == MODE_BOTH);
    case (r)
      REACT_RISE: return {rok, RISE_V};
      REACT_FALL: return {fok, FALL_V};
      REACT_STATE: return {f != FUNC_SCENE_MEM && m == MODE_BOTH, lvl ? RISE_V : FALL_V};
      default: return {1'b0, 16'h0000};
    endcase
  endfunction : exp_tx

  task automatic run_case(input logic [1:0] f, m, s, e, input logic pol, lvl);
    logic [15:0] ctrl;
    ctrl = {6'h00, e, s, m, f, pol, 1'b1};
    wr(ADDR_CTRL, ctrl & 16'hFFFE);
    obj(pol);
    pin(lvl);
    wr(ADDR_CTRL, ctrl);
    c0 = tx_count;
    obj(~pol);
    tx_chk(exp_tx(f, m, s, lvl), "start reaction");
    pin(~lvl);
    pin(lvl);
    tx_chk(17'h00000, "edge while disabled");
    rd_chk(ADDR_STAT, {14'h0000, lvl, 1'b1}, "status");
    obj(pol);
    tx_chk(exp_tx(f, m, e, lvl), "end reaction");
  endtask : run_case

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    tick(3);
    RSTN <= 1'b1;
    rd_chk(ADDR_CTRL, CTRL_RESET, "ctrl reset");
    rd_chk(ADDR_RISE, RISE_RESET, "rise reset");
    rd_chk(ADDR_STAT, 16'h0000, "status reset");
    wr(ADDR_RISE, RISE_V);
    wr(ADDR_FALL, FALL_V);
    rd_chk(ADDR_RISE, RISE_V, "rise value");
    rd_chk(ADDR_FALL, FALL_V, "fall value");
    // all-ones control disables at once, so switching the feature off ends it
    wr(ADDR_CTRL, 16'hFFFF);
    rd_chk(ADDR_CTRL, CTRL_MASK, "ctrl mask");
    wr(4'h5, 16'h1234);
    rd_chk(4'h5, 16'h0000, "unmapped");
    // feature off: object ignored and edges still go out
    wr(ADDR_CTRL, {6'h00, REACT_FALL, REACT_RISE, MODE_BOTH, FUNC_SCENE, 2'b00});
    c0 = tx_count;
    tx_chk({1'b1, FALL_V}, "feature switched off");
    obj(1'b1);
    tx_chk(17'h00000, "feature off");
    pin(1'b1);
    tx_chk({1'b1, RISE_V}, "rising edge");
    pin(1'b0);
    tx_chk({1'b1, FALL_V}, "falling edge");
    for (int f = 0; f < 3; f++) begin
      for (int m = 0; m < 4; m++) begin
        for (int r = 0; r < 4; r++) begin
          run_case(2'(f), 2'(m), 2'(r), 2'(3 - r), r[1], m[0] ^ r[0]);
        end
      end
    end
    print_verdict();
  end
endmodule : test_input_channel_disable_logic
